// >>> core/tps_interval_stats.sv
// Interval performance statistics with APB register access
//
// Our own choices: register access over APB and the address map.
module tps_interval_stats
  import tps_pkg::*;
#(
  parameter int CLKS_PER_SEC_P = CLKS_PER_SEC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Line event pins
  input wire tps_line_t linePins,
  // Interrupt
  output logic irq
);

  localparam int DIV_W = $clog2(CLKS_PER_SEC_P);

  if (CLKS_PER_SEC_P < 2) begin : g_bad
    $error("tps_interval_stats: CLKS_PER_SEC_P too small");
  end

  //----------------------------------------------------------------------
  // Pin synchronisers
  //----------------------------------------------------------------------
  logic [LINE_W-1:0] s1_q, s2_q, s3_q, stable_q, prev_q, stable_d;
  tps_line_t lvl, rise;

  // A level is accepted only once the second and third stages agree
  assign stable_d = (s2_q & s3_q) | (stable_q & (s2_q ^ s3_q));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      stable_q <= '0;
      prev_q <= '0;
    end else begin
      s1_q <= linePins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      stable_q <= stable_d;
      prev_q <= stable_q;
    end
  end

  assign lvl = stable_q;
  assign rise = stable_q & ~prev_q;

  //----------------------------------------------------------------------
  // Second tick and interval timer
  //----------------------------------------------------------------------
  logic [DIV_W-1:0] div_q, div_d;
  logic [SEC_CNT_W-1:0] ivSec_q, ivSec_d;
  logic tick, roll, clr_q, clr_d;

  assign tick = div_q == DIV_W'(CLKS_PER_SEC_P - 1);
  assign roll = tick && ivSec_q == SEC_CNT_W'(INTERVAL_S - 1);

  always_comb begin
    div_d = tick ? '0 : div_q + 1'b1;
    ivSec_d = ivSec_q;
    if (clr_q || roll) begin
      ivSec_d = '0;
    end else if (tick) begin
      ivSec_d = ivSec_q + 1'b1;
    end
    if (clr_q) begin
      div_d = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_q <= '0;
      ivSec_q <= '0;
    end else begin
      div_q <= div_d;
      ivSec_q <= ivSec_d;
    end
  end

  //----------------------------------------------------------------------
  // Current interval counters
  //----------------------------------------------------------------------
  tps_cur_t cur_q [NUM_SETS];
  tps_cur_t cur_d [NUM_SETS];
  tps_cur_t rollVal [NUM_SETS];
  logic [NUM_SETS-1:0] slipFlag_q, slipFlag_d, setOn;
  logic [NUM_SETS-1:0] lossSat;

  always_comb begin
    for (int s = 0; s < NUM_SETS; s++) begin
      // Aggregate sets are monitored only under extended superframe
      setOn[s] = (s < NUM_AGG_SETS) ? lvl.esfMode : 1'b1;
      slipFlag_d[s] = slipFlag_q[s] | (setOn[s] & rise.slip[s]);
      rollVal[s] = cur_q[s];
      if (tick && slipFlag_d[s]) begin
        rollVal[s].slip = cur_q[s].slip + 1'b1;
      end
      lossSat[s] = 1'b0;
      if (setOn[s] && rise.frameLossDeclared[s]) begin
        if (cur_q[s].loss == LOSS_MAX) begin
          lossSat[s] = 1'b1;
        end else begin
          rollVal[s].loss = cur_q[s].loss + 1'b1;
        end
      end
      cur_d[s] = rollVal[s];
      if (tick) begin
        slipFlag_d[s] = 1'b0;
      end
      if (roll || clr_q) begin
        cur_d[s] = '0;
        slipFlag_d[s] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      slipFlag_q <= '0;
      for (int s = 0; s < NUM_SETS; s++) begin
        cur_q[s] <= '0;
      end
    end else begin
      slipFlag_q <= slipFlag_d;
      for (int s = 0; s < NUM_SETS; s++) begin
        cur_q[s] <= cur_d[s];
      end
    end
  end

  //----------------------------------------------------------------------
  // Histories
  //----------------------------------------------------------------------
  logic [TOT_W-1:0] slipTot [NUM_SETS];
  logic [TOT_W-1:0] lossTot [NUM_SETS];
  logic [CNT_W-1:0] validCnt [NUM_SETS];
  logic histRoll;

  assign histRoll = roll && !clr_q;

  for (genvar s = 0; s < NUM_SETS; s++) begin : g_set
    localparam int D = (s < NUM_AGG_SETS) ? AGG_DEPTH : PORT_DEPTH;
    // Near-end and far-end port sets keep separate windows
    tps_history #(.DEPTH(D), .W(SLIP_W)) u_slip (
      .core_clk(core_clk),
      .rst(rst),
      .clr(clr_q),
      .roll(histRoll),
      .value(rollVal[s].slip),
      .total(slipTot[s]),
      .validCnt(validCnt[s])
    );
    tps_history #(.DEPTH(D), .W(LOSS_W)) u_loss (
      .core_clk(core_clk),
      .rst(rst),
      .clr(clr_q),
      .roll(histRoll),
      .value(rollVal[s].loss),
      .total(lossTot[s]),
      .validCnt()
    );
  end

  //----------------------------------------------------------------------
  // User events and far-end completeness
  //----------------------------------------------------------------------
  logic [EVT_W-1:0] evt_q, evt_d, lastEvt_q, lastEvt_d;
  logic [SEC_CNT_W-1:0] farSec_q, farSec_d, farNext;
  logic cpl_q, cpl_d, cplValid_q, cplValid_d, incomplete;

  always_comb begin
    // Flags are ORs of alarms seen under extended superframe, so a quiet interval reads 0
    evt_d = evt_q | (lvl.alarm & {EVT_W{lvl.esfMode}});
    lastEvt_d = lastEvt_q;
    farNext = farSec_q;
    if (rise.farReport && farSec_q != SEC_CNT_W'(INTERVAL_S)) begin
      farNext = farSec_q + 1'b1;
    end
    farSec_d = farNext;
    cpl_d = cpl_q;
    cplValid_d = cplValid_q;
    incomplete = 1'b0;
    if (roll) begin
      lastEvt_d = evt_d;
      evt_d = '0;
      cpl_d = farNext == SEC_CNT_W'(INTERVAL_S);
      incomplete = !cpl_d;
      cplValid_d = 1'b1;
      farSec_d = '0;
    end
    if (clr_q) begin
      evt_d = '0;
      lastEvt_d = '0;
      farSec_d = '0;
      cpl_d = 1'b0;
      cplValid_d = 1'b0;
      incomplete = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      evt_q <= '0;
      lastEvt_q <= '0;
      farSec_q <= '0;
      cpl_q <= 1'b0;
      cplValid_q <= 1'b0;
    end else begin
      evt_q <= evt_d;
      lastEvt_q <= lastEvt_d;
      farSec_q <= farSec_d;
      cpl_q <= cpl_d;
      cplValid_q <= cplValid_d;
    end
  end

  //----------------------------------------------------------------------
  // APB register file
  //----------------------------------------------------------------------
  logic farView_q, farView_d;
  logic [IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d, hwSet;
  logic [31:0] prdata_q, prdata_d, rdata;
  logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
  logic mapped, wrDone;
  logic [1:0] idx;

  assign idx = paddr[3:2];
  assign wrDone = psel && penable && pready_q && pwrite && mapped;
  assign hwSet = {incomplete, |lossSat, histRoll};

  always_comb begin
    rdata = '0;
    mapped = paddr[1:0] == 2'b00;
    case (paddr[7:4])
      OFF_CTRL[7:4]: begin
        case (paddr[3:0])
          OFF_CTRL[3:0]: rdata = 32'({farView_q, 1'b0});
          OFF_IRQ_STAT[3:0]: rdata = 32'(stat_q);
          OFF_IRQ_MASK[3:0]: rdata = 32'(mask_q);
          default: rdata = 32'(ivSec_q);
        endcase
      end
      OFF_CUR_BASE[7:4]:
        rdata = 32'(cur_q[idx].slip)
          | (32'(cur_q[idx].loss) << CUR_LOSS_LSB);
      OFF_SLIPTOT_BASE[7:4]: rdata = 32'(slipTot[idx]);
      OFF_LOSSTOT_BASE[7:4]: rdata = 32'(lossTot[idx]);
      OFF_VALID_BASE[7:4]: rdata = 32'(validCnt[idx]);
      OFF_EVENTS[7:4]: begin
        if (paddr[3:0] == OFF_EVENTS[3:0]) begin
          rdata = 32'(evt_q) | (32'(lastEvt_q) << EVT_LAST_LSB);
        end else if (paddr[3:0] == OFF_COMPLETE[3:0]) begin
          // Near-end view hides the far-end completeness entirely
          if (farView_q) begin
            rdata = 32'({cplValid_q, cpl_q});
          end
        end else begin
          mapped = 1'b0;
        end
      end
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    // One wait state: data is captured on the first access cycle
    pready_d = psel && penable && !pready_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (pready_d) begin
      prdata_d = (pwrite || !mapped) ? '0 : rdata;
      pslverr_d = !mapped;
    end
    farView_d = farView_q;
    mask_d = mask_q;
    clr_d = 1'b0;
    stat_d = stat_q;
    if (wrDone && paddr == OFF_CTRL) begin
      farView_d = pwdata[CTRL_FARVIEW_BIT];
      clr_d = pwdata[CTRL_CLEAR_BIT];
    end
    if (wrDone && paddr == OFF_IRQ_MASK) begin
      mask_d = pwdata[IRQ_W-1:0];
    end
    if (wrDone && paddr == OFF_IRQ_STAT) begin
      stat_d = stat_q & ~pwdata[IRQ_W-1:0];
    end
    // A hardware event in the clearing cycle survives the clear
    stat_d = stat_d | hwSet;
    irq_d = |(stat_q & mask_q);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      farView_q <= 1'b0;
      mask_q <= IRQ_MASK_RST;
      stat_q <= '0;
      clr_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      farView_q <= farView_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      clr_q <= clr_d;
      irq_q <= irq_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

endmodule // tps_interval_stats

// >>> core/tps_pkg.sv
// Constants, register map and carrier types for the interval statistics
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package tps_pkg;

  localparam int NUM_SETS = 4;
  localparam int SET_CARRIER = 0;
  localparam int SET_USER = 1;
  localparam int SET_NEAR = 2;
  localparam int SET_FAR = 3;
  localparam int NUM_AGG_SETS = 2;

  localparam int AGG_HOURS = 24;
  localparam int PORT_HOURS = 8;
  localparam int INTERVAL_MIN = 15;
  localparam int INTERVAL_S = INTERVAL_MIN * 60;
  localparam int AGG_DEPTH = AGG_HOURS * 60 / INTERVAL_MIN;
  localparam int PORT_DEPTH = PORT_HOURS * 60 / INTERVAL_MIN;

  localparam longint SEC_NS = 1000000000;
  localparam longint CLK_NS = 10;
  localparam int CLKS_PER_SEC = int'(SEC_NS / CLK_NS);

  localparam int SLIP_W = 10;
  localparam int LOSS_W = 8;
  localparam logic [LOSS_W-1:0] LOSS_MAX = 8'hff;
  localparam int TOT_W = 17;
  localparam int CNT_W = 7;
  localparam int EVT_W = 5;
  localparam int SEC_CNT_W = 10;

  localparam int EVT_YELLOW = 0;
  localparam int EVT_DI_LOSS = 1;
  localparam int EVT_EXCESS = 2;
  localparam int EVT_FBIT = 3;
  localparam int EVT_BPV = 4;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_TIMER = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_CUR_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_SLIPTOT_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_LOSSTOT_BASE = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_VALID_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_EVENTS = 8'h50;
  localparam logic [ADDR_W-1:0] OFF_COMPLETE = 8'h54;

  localparam int CTRL_CLEAR_BIT = 0;
  localparam int CTRL_FARVIEW_BIT = 1;
  localparam int CUR_LOSS_LSB = 16;
  localparam int EVT_LAST_LSB = 8;
  localparam int CPL_VALID_BIT = 1;

  localparam int IRQ_ROLL = 0;
  localparam int IRQ_LOSS_SAT = 1;
  localparam int IRQ_INCOMPLETE = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  typedef struct packed {
    logic esfMode;
    logic [EVT_W-1:0] alarm;
    logic farReport;
    logic [NUM_SETS-1:0] frameLossDeclared;
    logic [NUM_SETS-1:0] slip;
  } tps_line_t;

  typedef struct packed {
    logic [SLIP_W-1:0] slip;
    logic [LOSS_W-1:0] loss;
  } tps_cur_t;

  localparam int LINE_W = $bits(tps_line_t);

endpackage

// >>> core/tps_history.sv
// Rolling interval history with running total and valid-interval count
module tps_history
  import tps_pkg::*;
#(
  parameter int DEPTH = AGG_DEPTH,
  parameter int W = SLIP_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic clr,
  input wire logic roll,
  input wire logic [W-1:0] value,
  // Results
  output logic [TOT_W-1:0] total,
  output logic [CNT_W-1:0] validCnt
);

  localparam int PTR_W = $clog2(DEPTH);

  if (DEPTH < 2 || DEPTH >= (1 << CNT_W) || W > TOT_W) begin : g_bad
    $error("tps_history: unsupported DEPTH or W");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] ptr_q, ptr_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [TOT_W-1:0] tot_q, tot_d;
  logic full;

  assign full = cnt_q == CNT_W'(DEPTH);

  always_comb begin
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    tot_d = tot_q;
    if (clr) begin
      ptr_d = '0;
      cnt_d = '0;
      tot_d = '0;
    end else if (roll) begin
      // Once full, the oldest interval leaves the window as the new one enters
      tot_d = tot_q + TOT_W'(value) - (full ? TOT_W'(mem_q[ptr_q]) : '0);
      ptr_d = (ptr_q == PTR_W'(DEPTH - 1)) ? '0 : ptr_q + 1'b1;
      if (!full) begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ptr_q <= '0;
      cnt_q <= '0;
      tot_q <= '0;
    end else begin
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      tot_q <= tot_d;
    end
  end

  // Entries beyond cnt_q are never read, so they need no reset
  always_ff @(posedge core_clk) begin
    if (roll && !clr) begin
      mem_q[ptr_q] <= value;
    end
  end

  assign total = tot_q;
  assign validCnt = cnt_q;

endmodule // tps_history

// >>> sim/tps_interval_stats_sva.sv
// Port-level checks for the interval statistics block
module tps_interval_stats_sva
  import tps_pkg::*;
#(
  parameter int CLKS_PER_SEC_P = CLKS_PER_SEC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Line pins and interrupt
  input wire tps_line_t linePins,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic farView_q;
  logic farView_d;
  logic [IRQ_W-1:0] mask_q;
  logic [IRQ_W-1:0] mask_d;
  logic wrDone;
  logic rdDone;
  assign wrDone = pready && pwrite && !pslverr;
  assign rdDone = pready && !pwrite && !pslverr;
  // Shadow copies, taken at the completing edge like the real registers
  always_comb begin
    farView_d = farView_q;
    mask_d = mask_q;
    if (wrDone && paddr == OFF_CTRL) begin
      farView_d = pwdata[CTRL_FARVIEW_BIT];
    end
    if (wrDone && paddr == OFF_IRQ_MASK) begin
      mask_d = pwdata[IRQ_W-1:0];
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      farView_q <= 1'b0;
      mask_q <= IRQ_MASK_RST;
    end else begin
      farView_q <= farView_d;
      mask_q <= mask_d;
    end
  end
  //----------------------------------------------------------------------
  // Properties
  //----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_open;
    psel && $rose(penable);
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  a_ready_wait: assert property (s_open |-> s_answer)
    else $error("pready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_unalign: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned access not refused");
  a_err_quiet: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  a_rst_quiet: assert property (disable iff (1'b0)
    rst |=> !pready && !pslverr && !irq && prdata == 32'h0)
    else $error("outputs active after reset");
  a_clear_self: assert property (rdDone && paddr == OFF_CTRL
    |-> !prdata[CTRL_CLEAR_BIT]) else $error("clear bit reads one");
  a_cpl_hidden: assert property (rdDone && paddr == OFF_COMPLETE
    && !farView_q |-> prdata == 32'h0) else $error("completeness shown");
  a_timer_range: assert property (rdDone && paddr == OFF_TIMER
    |-> prdata < INTERVAL_S) else $error("timer beyond interval");
  a_agg_valid: assert property (rdDone && paddr[7:3] == 5'h08
    |-> prdata <= AGG_DEPTH) else $error("aggregate valid count high");
  a_port_valid: assert property (rdDone && paddr[7:3] == 5'h09
    |-> prdata <= PORT_DEPTH) else $error("port valid count high");
  a_evt_width: assert property (rdDone && paddr == OFF_EVENTS
    |-> prdata[31:13] == 0 && prdata[7:5] == 0) else $error("stray flag");
  a_irq_masked: assert property ($past(mask_q) == 3'h0 |-> !irq)
    else $error("irq with all sources masked");
endmodule // tps_interval_stats_sva

bind tps_interval_stats tps_interval_stats_sva #(
  .CLKS_PER_SEC_P(CLKS_PER_SEC_P)
) u_sva (
  .core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .linePins(linePins), .irq(irq)
);

// >>> sim/tps_line_model.sv
// Line and far-end report source facing the statistics block
module tps_line_model
  import tps_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Far-end report enable
  input wire logic farEn,
  // Pins toward the block
  output tps_line_t linePins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic esf = 1'b0;
  logic [EVT_W-1:0] alarm = '0;
  logic [NUM_SETS-1:0] loss = '0;
  logic [NUM_SETS-1:0] slip = '0;
  logic far = 1'b0;
  int phase = 0;
  assign linePins = {esf, alarm, far, loss, slip};
  // One report per 9 cycles while farEn is high: a whole interval then holds 900 or more
  always @(posedge core_clk) begin
    phase <= (phase == 8) ? 0 : phase + 1;
    far <= farEn && phase < 4;
  end
  task automatic drive(input logic e, input logic [EVT_W-1:0] a);
    @(posedge core_clk);
    esf <= e;
    alarm <= a;
  endtask
  // Levels held 3 cycles or more so the input synchroniser accepts them
  task automatic pulse(input logic isLoss, input logic [NUM_SETS-1:0] m,
      input int n, input int gap);
    repeat (n) begin
      @(posedge core_clk);
      if (isLoss) begin
        loss <= m;
      end else begin
        slip <= m;
      end
      repeat (3) @(posedge core_clk);
      loss <= '0;
      slip <= '0;
      repeat (gap) @(posedge core_clk);
    end
  endtask
endmodule // tps_line_model

// >>> sim/tb_tps_interval_stats.sv
// Self-checking bench for the interval statistics block
module tb_tps_interval_stats
  import tps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic err;
  } tps_row_t;
  localparam tps_row_t ROWS [10] = '{
    '{OFF_CTRL, 32'h0, 1'b0}, '{OFF_IRQ_STAT, 32'h0, 1'b0},
    '{OFF_IRQ_MASK, 32'h0, 1'b0}, '{OFF_CUR_BASE, 32'h0, 1'b0},
    '{OFF_SLIPTOT_BASE, 32'h0, 1'b0}, '{OFF_VALID_BASE, 32'h0, 1'b0},
    '{OFF_EVENTS, 32'h0, 1'b0}, '{OFF_COMPLETE, 32'h0, 1'b0},
    '{8'h58, 32'h0, 1'b1}, '{8'h02, 32'h0, 1'b1}};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  tps_line_t linePins;
  logic irq;
  logic farEn = 1'b1;
  int num_errors = 0;
  int checked = 0;
  always #5 core_clk = ~core_clk;
  tps_interval_stats #(.CLKS_PER_SEC_P(10)) uut (
    .core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .linePins(linePins), .irq(irq));
  tps_line_model line (.core_clk(core_clk), .farEn(farEn),
    .linePins(linePins));
  //----------------------------------------------------------------------
  // Tasks
  //----------------------------------------------------------------------
  task automatic test_done();
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex,
      input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
      num_errors++;
    end
  endtask
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] ex,
      input string nm);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    chk(nm, ex, rd);
  endtask
  // Polling keeps the bench free of any assumed rollover cycle
  task automatic wait_roll(output logic [31:0] st);
    logic e;
    st = '0;
    while (st[IRQ_ROLL] !== 1'b1) begin
      apb(1'b0, OFF_IRQ_STAT, 32'h0, st, e);
    end
  endtask
  initial begin
    repeat (40000) @(posedge core_clk);
    num_errors++;
    test_done();
  end
  initial begin
    logic [31:0] rd;
    logic e;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    foreach (ROWS[i]) begin
      apb(1'b0, ROWS[i].addr, 32'h0, rd, e);
      chk("row data", ROWS[i].data, rd);
      chk("row err", {31'h0, ROWS[i].err}, {31'h0, e});
    end
    apb(1'b0, OFF_TIMER, 32'h0, rd, e);
    chk("timer", 32'h1, {31'h0, rd < 32'd900});
    line.pulse(1'b0, 4'h5, 1, 17);
    line.drive(1'b0, 5'h1f);
    repeat (8) @(posedge core_clk);
    line.drive(1'b1, 5'h00);
    rdchk(OFF_EVENTS, 32'h0, "events no esf");
    line.pulse(1'b0, 4'h7, 3, 17);
    for (int i = 0; i < EVT_W; i++) begin
      line.drive(1'b1, 5'h01 << i);
      repeat (8) @(posedge core_clk);
      rdchk(OFF_EVENTS, (32'h1 << (i + 1)) - 32'h1, "events");
    end
    line.drive(1'b1, 5'h00);
    line.pulse(1'b1, 4'h1, 2, 3);
    line.pulse(1'b1, 4'h4, 258, 3);
    repeat (20) @(posedge core_clk);
    rdchk(OFF_CUR_BASE, 32'h00020003, "cur carrier");
    rdchk(OFF_CUR_BASE + 8'h04, 32'h00000003, "cur user");
    rdchk(OFF_CUR_BASE + 8'h08, 32'h00ff0004, "cur near");
    rdchk(OFF_IRQ_STAT, 32'h2, "stat sat");
    apb(1'b1, OFF_IRQ_MASK, 32'h2, rd, e);
    repeat (3) @(posedge core_clk);
    chk("irq on", 32'h1, {31'h0, irq});
    apb(1'b1, OFF_IRQ_STAT, 32'h2, rd, e);
    repeat (3) @(posedge core_clk);
    chk("irq off", 32'h0, {31'h0, irq});
    wait_roll(rd);
    apb(1'b1, OFF_IRQ_STAT, 32'h7, rd, e);
    apb(1'b1, OFF_CTRL, 32'h2, rd, e);
    farEn <= 1'b0;
    rdchk(OFF_SLIPTOT_BASE, 32'h3, "slip total");
    rdchk(OFF_LOSSTOT_BASE, 32'h2, "loss total agg");
    rdchk(OFF_LOSSTOT_BASE + 8'h08, 32'hff, "loss total port");
    rdchk(OFF_LOSSTOT_BASE + 8'h0c, 32'h0, "loss total far");
    rdchk(OFF_SLIPTOT_BASE + 8'h08, 32'h4, "slip total near");
    rdchk(OFF_VALID_BASE, 32'h1, "valid agg");
    rdchk(OFF_VALID_BASE + 8'h0c, 32'h1, "valid far");
    rdchk(OFF_CUR_BASE, 32'h0, "cur cleared");
    rdchk(OFF_EVENTS, 32'h1f00, "events last");
    rdchk(OFF_COMPLETE, 32'h3, "complete");
    wait_roll(rd);
    chk("stat roll", 32'h5, rd);
    rdchk(OFF_COMPLETE, 32'h2, "incomplete");
    rdchk(OFF_EVENTS, 32'h0, "events none");
    rdchk(OFF_SLIPTOT_BASE, 32'h3, "slip two");
    rdchk(OFF_VALID_BASE, 32'h2, "valid two");
    apb(1'b1, OFF_CTRL, 32'h0, rd, e);
    rdchk(OFF_COMPLETE, 32'h0, "hidden");
    apb(1'b1, OFF_CTRL, 32'h1, rd, e);
    rdchk(OFF_SLIPTOT_BASE, 32'h0, "slip clr");
    rdchk(OFF_VALID_BASE, 32'h0, "valid clr");
    test_done();
  end
endmodule // tb_tps_interval_stats
